// file: shared/acrb_consts.svh
`ifndef ACRB_CONSTS_SVH
`define ACRB_CONSTS_SVH
// Register offsets.
`define ACRB_OFS_PORT_CFG 8'h00
`define ACRB_OFS_CHAN_SEL 8'h05
`define ACRB_OFS_POWER 8'h08
`define ACRB_OFS_CLOCK 8'h09
`define ACRB_OFS_CLKDIV 8'h0b
`define ACRB_OFS_ENHANCE 8'h0c
`define ACRB_OFS_TEST 8'h0d
`define ACRB_OFS_COMMIT 8'hff
// Reset values.
`define ACRB_RST_PORT_CFG 8'h18
`define ACRB_RST_CHAN_SEL 8'h33
`define ACRB_RST_ZERO 8'h00
// Field positions.
`define ACRB_BIT_SOFT_HI 5
`define ACRB_BIT_SOFT_LO 2
`define ACRB_BIT_SEL_A 0
`define ACRB_BIT_SEL_B 1
`define ACRB_BIT_CHOP 2
`define ACRB_BIT_PN_LONG_RST 5
`define ACRB_CHAN_SEL_MASK 8'h33
// Power mode codes.
`define ACRB_PWR_RUN 2'h0
`define ACRB_PWR_DOWN 2'h1
`define ACRB_PWR_STANDBY 2'h2
`define ACRB_PWR_HOLD 2'h3
// Test register value for code 1000 with user words alternating.
`define ACRB_TEST_USER_ALT 8'h48
// Output test codes.
`define ACRB_TST_OFF 4'h0
`define ACRB_TST_MID 4'h1
`define ACRB_TST_POS_FS 4'h2
`define ACRB_TST_NEG_FS 4'h3
`define ACRB_TST_CHECKER 4'h4
`define ACRB_TST_PN_LONG 4'h5
`define ACRB_TST_WORD_TGL 4'h7
`define ACRB_TST_USER 4'h8
`define ACRB_TST_BIT_TGL 4'h9
`define ACRB_TST_SYNC 4'ha
`define ACRB_TST_ONE_HIGH 4'hb
`define ACRB_TST_MIXED 4'hc
// Pattern words.
`define ACRB_W_MID 12'h800
`define ACRB_W_POS_FS 12'hfff
`define ACRB_W_NEG_FS 12'h000
`define ACRB_W_CHK_A 12'haaa
`define ACRB_W_CHK_B 12'h555
`define ACRB_W_SYNC 12'h03f
`define ACRB_W_ONE_HIGH 12'h001
`define ACRB_W_MIX_A 12'h0f3
`define ACRB_W_MIX_B 12'hf0c
// Long pseudorandom generator: 23 stages, taps at 23 and 18.
`define ACRB_PN_SEED 23'h7f_ffff
`define ACRB_PN_TAP 17
`endif

// file: shared/acrb_pkg.sv
package acrb_pkg;
	typedef enum logic [1:0] {USR_FIRST, USR_SECOND, USR_IDLE} acrb_usr_t;
	typedef logic [7:0] acrb_byte_t;
endpackage

// file: design/acrb_top.sv
`timescale 1ns/1ps
`include "acrb_consts.svh"
// How it works
// [RQ1] Power field: 00 run, 01 full power-down, 10 standby, 11 held reset.
// [RQ2] Test codes 0..3: normal data, midscale, positive and negative full-scale words.
// [RQ3] Code 0100 emits checkerboard words, code 0101 the 23-stage pseudorandom sequence.
// [RQ4] Codes 0111, 1000, 1001: word toggle, user pattern words, single-bit toggle.
// [RQ5] Codes 1010, 1011, 1100: sync word, one bit high, mixed frequency.
// [RQ6] Bits 7:6 of test register choose how user pattern words are sequenced.
// [RQ7] With all select bits set, a local write updates both channel copies.
// [RQ8] A read with channel A selected, or all selected, returns channel A.
// [RQ9] Soft reset bit restores every user register, then clears itself.
// [RQ10] Writing one to commit bit pulses the override commit; bit reads zero after.
module acrb_top #(
	parameter int DW = 12
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Register access from the serial port framer.
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire acrb_pkg::acrb_byte_t reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Conversion data and user pattern words.
	input wire logic [DW-1:0] conv_a,
	input wire logic [DW-1:0] conv_b,
	input wire logic [DW-1:0] user_word1,
	input wire logic [DW-1:0] user_word2,
	// Lane data and sample tick.
	output logic [DW-1:0] lane_a,
	output logic [DW-1:0] lane_b,
	output logic sample_tick,
	// Chip controls.
	output logic chip_run,
	output logic power_down,
	output logic standby,
	output logic chip_hold_reset,
	output logic dcs_enable,
	output logic chop_enable,
	output logic [2:0] clock_divide,
	output logic override_commit
);
	import acrb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] chan_sel, pwr_reg, clk_reg, div_reg, enh_reg, test_a, test_b;
	logic commit_bit, soft_pend;
	logic [7:0] next_chan_sel, next_pwr_reg, next_clk_reg, next_div_reg, next_enh_reg;
	logic [7:0] next_test_a, next_test_b, next_rdata;
	logic next_commit_bit, next_soft_pend, next_rvalid;
	logic wr_local_a, wr_local_b;

	always_comb begin
		next_chan_sel = chan_sel;
		next_pwr_reg = pwr_reg;
		next_clk_reg = clk_reg;
		next_div_reg = div_reg;
		next_enh_reg = enh_reg;
		next_test_a = test_a;
		next_test_b = test_b;
		next_commit_bit = 1'b0; // RQ10
		next_soft_pend = 1'b0; // RQ9
		next_rvalid = reg_rd;
		next_rdata = reg_rdata;
		wr_local_a = reg_wr && reg_addr == `ACRB_OFS_TEST && chan_sel[`ACRB_BIT_SEL_A]; // RQ7
		wr_local_b = reg_wr && reg_addr == `ACRB_OFS_TEST && chan_sel[`ACRB_BIT_SEL_B]; // RQ7
		if (reg_wr) begin
			case (reg_addr)
				`ACRB_OFS_PORT_CFG: next_soft_pend = reg_wdata[`ACRB_BIT_SOFT_HI]
					| reg_wdata[`ACRB_BIT_SOFT_LO]; // RQ9
				`ACRB_OFS_CHAN_SEL: next_chan_sel = reg_wdata & `ACRB_CHAN_SEL_MASK;
				`ACRB_OFS_POWER: next_pwr_reg = {6'h00, reg_wdata[1:0]};
				`ACRB_OFS_CLOCK: next_clk_reg = {7'h00, reg_wdata[0]};
				`ACRB_OFS_CLKDIV: next_div_reg = {5'h00, reg_wdata[2:0]};
				`ACRB_OFS_ENHANCE: next_enh_reg = reg_wdata & (8'h01 << `ACRB_BIT_CHOP);
				`ACRB_OFS_COMMIT: next_commit_bit = reg_wdata[0]; // RQ10
				default: ;
			endcase
		end
		if (wr_local_a) begin
			next_test_a = reg_wdata;
		end
		if (wr_local_b) begin
			next_test_b = reg_wdata;
		end
		if (reg_rd) begin
			case (reg_addr)
				`ACRB_OFS_PORT_CFG: next_rdata = `ACRB_RST_PORT_CFG;
				`ACRB_OFS_CHAN_SEL: next_rdata = chan_sel;
				`ACRB_OFS_POWER: next_rdata = pwr_reg;
				`ACRB_OFS_CLOCK: next_rdata = clk_reg;
				`ACRB_OFS_CLKDIV: next_rdata = div_reg;
				`ACRB_OFS_ENHANCE: next_rdata = enh_reg;
				`ACRB_OFS_TEST: next_rdata = (chan_sel[`ACRB_BIT_SEL_A]
					|| !chan_sel[`ACRB_BIT_SEL_B]) ? test_a : test_b; // RQ8
				`ACRB_OFS_COMMIT: next_rdata = {7'h00, commit_bit};
				default: next_rdata = `ACRB_RST_ZERO;
			endcase
		end
		// Soft reset is applied a cycle after the write; port config reads return the fixed reset value, so the bit never reads as one.
		if (soft_pend) begin
			next_chan_sel = `ACRB_RST_CHAN_SEL; // RQ9
			next_pwr_reg = `ACRB_RST_ZERO;
			next_clk_reg = `ACRB_RST_ZERO;
			next_div_reg = `ACRB_RST_ZERO;
			next_enh_reg = `ACRB_RST_ZERO;
			next_test_a = `ACRB_RST_ZERO;
			next_test_b = `ACRB_RST_ZERO;
			next_commit_bit = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			chan_sel <= `ACRB_RST_CHAN_SEL;
			pwr_reg <= `ACRB_RST_ZERO;
			clk_reg <= `ACRB_RST_ZERO;
			div_reg <= `ACRB_RST_ZERO;
			enh_reg <= `ACRB_RST_ZERO;
			test_a <= `ACRB_RST_ZERO;
			test_b <= `ACRB_RST_ZERO;
			commit_bit <= 1'b0;
			soft_pend <= 1'b0;
			reg_rvalid <= 1'b0;
			reg_rdata <= `ACRB_RST_ZERO;
		end else begin
			chan_sel <= next_chan_sel;
			pwr_reg <= next_pwr_reg;
			clk_reg <= next_clk_reg;
			div_reg <= next_div_reg;
			enh_reg <= next_enh_reg;
			test_a <= next_test_a;
			test_b <= next_test_b;
			commit_bit <= next_commit_bit;
			soft_pend <= next_soft_pend;
			reg_rvalid <= next_rvalid;
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// User pattern sequencing for one channel.
	function automatic acrb_usr_t usr_step(input logic [7:0] tst, input acrb_usr_t st);
		if (tst[3:0] != `ACRB_TST_USER) begin
			usr_step = USR_FIRST;
		end else begin
			case (st)
				USR_FIRST: usr_step = tst[6] ? USR_SECOND : (tst[7] ? USR_IDLE : USR_FIRST); // RQ6
				USR_SECOND: usr_step = tst[7] ? USR_IDLE : USR_FIRST; // RQ6
				default: usr_step = USR_IDLE;
			endcase
		end
	endfunction

	// Word placed on a lane for a given test code.
	function automatic logic [DW-1:0] pick(input logic [3:0] code, input logic ph,
		input logic [DW-1:0] conv, input logic [22:0] pn, input acrb_usr_t st);
		case (code)
			`ACRB_TST_MID: pick = `ACRB_W_MID; // RQ2
			`ACRB_TST_POS_FS: pick = `ACRB_W_POS_FS; // RQ2
			`ACRB_TST_NEG_FS: pick = `ACRB_W_NEG_FS; // RQ2
			`ACRB_TST_CHECKER: pick = ph ? `ACRB_W_CHK_B : `ACRB_W_CHK_A; // RQ3
			`ACRB_TST_PN_LONG: pick = pn[22 -: DW]; // RQ3
			`ACRB_TST_WORD_TGL: pick = ph ? `ACRB_W_NEG_FS : `ACRB_W_POS_FS; // RQ4
			`ACRB_TST_USER: pick = (st == USR_FIRST) ? user_word1
				: ((st == USR_SECOND) ? user_word2 : `ACRB_W_NEG_FS); // RQ4
			`ACRB_TST_BIT_TGL: pick = `ACRB_W_CHK_A; // RQ4
			`ACRB_TST_SYNC: pick = `ACRB_W_SYNC; // RQ5
			`ACRB_TST_ONE_HIGH: pick = `ACRB_W_ONE_HIGH; // RQ5
			`ACRB_TST_MIXED: pick = ph ? `ACRB_W_MIX_B : `ACRB_W_MIX_A; // RQ5
			default: pick = conv; // RQ2
		endcase
	endfunction

	logic [2:0] div_cnt, next_div_cnt;
	logic phase, next_phase, tick, next_tick;
	logic [22:0] pn_reg, next_pn_reg;
	acrb_usr_t usr_a, usr_b, next_usr_a, next_usr_b;
	logic [DW-1:0] next_lane_a, next_lane_b;
	logic next_run, next_down, next_stby, next_hold;

	always_comb begin
		tick = div_cnt == div_reg[2:0];
		next_div_cnt = tick ? 3'h0 : div_cnt + 3'h1;
		next_tick = tick;
		next_phase = tick ? ~phase : phase;
		next_pn_reg = pn_reg;
		next_usr_a = usr_a;
		next_usr_b = usr_b;
		next_lane_a = lane_a;
		next_lane_b = lane_b;
		if (tick) begin
			next_pn_reg = {pn_reg[21:0], pn_reg[22] ^ pn_reg[`ACRB_PN_TAP]}; // RQ3
			next_usr_a = usr_step(test_a, usr_a);
			next_usr_b = usr_step(test_b, usr_b);
			next_lane_a = pick(test_a[3:0], phase, conv_a, pn_reg, usr_a);
			next_lane_b = pick(test_b[3:0], phase, conv_b, pn_reg, usr_b);
		end
		if (test_a[`ACRB_BIT_PN_LONG_RST] || test_b[`ACRB_BIT_PN_LONG_RST]) begin
			next_pn_reg = `ACRB_PN_SEED;
		end
		next_run = pwr_reg[1:0] == `ACRB_PWR_RUN; // RQ1
		next_down = pwr_reg[1:0] == `ACRB_PWR_DOWN; // RQ1
		next_stby = pwr_reg[1:0] == `ACRB_PWR_STANDBY; // RQ1
		next_hold = !next_run && !next_down && !next_stby; // RQ1
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_cnt <= 3'h0;
			phase <= 1'b0;
			sample_tick <= 1'b0;
			pn_reg <= `ACRB_PN_SEED;
			usr_a <= USR_FIRST;
			usr_b <= USR_FIRST;
			lane_a <= '0;
			lane_b <= '0;
			chip_run <= 1'b1;
			power_down <= 1'b0;
			standby <= 1'b0;
			chip_hold_reset <= 1'b0;
			dcs_enable <= 1'b0;
			chop_enable <= 1'b0;
			clock_divide <= 3'h0;
			override_commit <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			phase <= next_phase;
			sample_tick <= next_tick;
			pn_reg <= next_pn_reg;
			usr_a <= next_usr_a;
			usr_b <= next_usr_b;
			lane_a <= next_lane_a;
			lane_b <= next_lane_b;
			chip_run <= next_run;
			power_down <= next_down;
			standby <= next_stby;
			chip_hold_reset <= next_hold;
			dcs_enable <= clk_reg[0];
			chop_enable <= enh_reg[`ACRB_BIT_CHOP];
			clock_divide <= div_reg[2:0];
			override_commit <= commit_bit; // RQ10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_power_down_dec: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
		$past(pwr_reg[1:0] == `ACRB_PWR_DOWN) |-> power_down && !chip_run)
		else $error("power-down decode wrong");
	a_power_hold_dec: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ1
		$past(pwr_reg[1:0] == `ACRB_PWR_HOLD) |-> chip_hold_reset && !standby)
		else $error("reset-hold decode wrong");
	a_midscale_word: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
		tick && test_a[3:0] == `ACRB_TST_MID |=> lane_a == `ACRB_W_MID)
		else $error("midscale word missing");
	a_normal_data: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ2
		tick && test_b[3:0] == `ACRB_TST_OFF |=> lane_b == $past(conv_b))
		else $error("normal data not passed");
	a_checker_alt: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ3
		tick && test_a[3:0] == `ACRB_TST_CHECKER |=> lane_a == (phase ? `ACRB_W_CHK_A
			: `ACRB_W_CHK_B))
		else $error("checkerboard wrong");
	a_word_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ4
		tick && test_a[3:0] == `ACRB_TST_WORD_TGL |=> lane_a == {DW{!$past(phase)}})
		else $error("word toggle wrong");
	a_sync_word: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ5
		tick && test_b[3:0] == `ACRB_TST_SYNC |=> lane_b == `ACRB_W_SYNC)
		else $error("sync word wrong");
	a_user_alt: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ6
		tick && test_a == `ACRB_TEST_USER_ALT && usr_a == USR_FIRST |=> usr_a == USR_SECOND)
		else $error("user sequencing wrong");
	a_local_both: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ7
		reg_wr && reg_addr == `ACRB_OFS_TEST && chan_sel == `ACRB_RST_CHAN_SEL && !soft_pend
		|=> test_a == $past(reg_wdata) && test_b == $past(reg_wdata))
		else $error("broadcast write lost");
	a_read_chan_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ8
		reg_rd && reg_addr == `ACRB_OFS_TEST && chan_sel[`ACRB_BIT_SEL_A]
		|=> reg_rdata == $past(test_a))
		else $error("read did not return channel A");
	a_soft_reset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ9
		reg_wr && reg_addr == `ACRB_OFS_PORT_CFG && reg_wdata[`ACRB_BIT_SOFT_HI]
		|=> ##1 chan_sel == `ACRB_RST_CHAN_SEL && test_a == `ACRB_RST_ZERO && !soft_pend)
		else $error("soft reset failed");
	a_commit_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) // RQ10
		reg_wr && reg_addr == `ACRB_OFS_COMMIT && reg_wdata[0] && !soft_pend
		|=> commit_bit ##1 override_commit && !commit_bit)
		else $error("commit pulse wrong");
endmodule

// file: verification/acrb_host_model.sv
`timescale 1ns/1ps
// Host side of the register port.
// Released lines show the inverse of the last value, so a late sample never matches by luck.
module acrb_host_model (
	// Clock.
	input wire logic sys_clk,
	// Register access.
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output acrb_pkg::acrb_byte_t reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	import acrb_pkg::*;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input acrb_byte_t x);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~x;
	endtask
	// The caller selects one data channel, or both, before reading a local register.
	task automatic rd(input logic [7:0] a, output logic [7:0] x, output logic v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		x = reg_rdata;
		v = reg_rvalid;
	endtask
endmodule

// file: verification/acrb_top_bench.sv
`timescale 1ns/1ps
`include "acrb_consts.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module acrb_top_bench;
	import acrb_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr, reg_rd, reg_rvalid, sample_tick, chip_run, power_down, standby, v;
	logic chip_hold_reset, dcs_enable, chop_enable, override_commit;
	logic [7:0] reg_addr, reg_rdata, d;
	acrb_byte_t reg_wdata;
	logic [11:0] conv_a = 12'h123, conv_b = 12'h456, user_word1 = 12'h5a1;
	logic [11:0] user_word2 = 12'h0c3, lane_a, lane_b, prev;
	logic [2:0] clock_divide;
	logic [3:0] codes[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'h8};
	logic [11:0] words[8] = '{12'h123, `ACRB_W_MID, `ACRB_W_POS_FS, `ACRB_W_NEG_FS,
		12'haaa, `ACRB_W_SYNC, `ACRB_W_ONE_HIGH, 12'h5a1};
	logic [3:0] alts[3] = '{4'h4, 4'h7, 4'hc};
	logic [11:0] his[3] = '{12'haaa, 12'hfff, `ACRB_W_MIX_A};
	int errors = 0, tests_run = 0, cyc = 0, k;
	always #50 sys_clk = ~sys_clk;
	acrb_top #(.DW(12)) acrb_top_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_a(conv_a), .conv_b(conv_b),
		.user_word1(user_word1), .user_word2(user_word2), .lane_a(lane_a), .lane_b(lane_b),
		.sample_tick(sample_tick), .chip_run(chip_run), .power_down(power_down),
		.standby(standby), .chip_hold_reset(chip_hold_reset), .dcs_enable(dcs_enable),
		.chop_enable(chop_enable), .clock_divide(clock_divide),
		.override_commit(override_commit));
	acrb_host_model host_inst (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_inst.rd(a, d, v);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask
	task automatic tst(input logic [7:0] x);
		host_inst.wr(`ACRB_OFS_TEST, x);
		ticks(3);
	endtask
	// A hang anywhere ends the run through the same report.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rchk(`ACRB_OFS_CHAN_SEL, `ACRB_RST_CHAN_SEL);
		rchk(`ACRB_OFS_PORT_CFG, `ACRB_RST_PORT_CFG);
		rchk(`ACRB_OFS_POWER, 8'h00);
		rchk(8'h13, 8'h00);
		for (k = 0; k < 4; k++) begin
			host_inst.wr(`ACRB_OFS_POWER, 8'(k));
			ticks(3);
			`CHK({chip_run, power_down, standby, chip_hold_reset}, 4'b1000 >> k)
		end
		host_inst.wr(`ACRB_OFS_CLOCK, 8'h01);
		host_inst.wr(`ACRB_OFS_ENHANCE, 8'h04);
		host_inst.wr(`ACRB_OFS_CLKDIV, 8'h02);
		ticks(3);
		`CHK({dcs_enable, chop_enable, clock_divide}, 5'b1_1010)
		k = 0;
		repeat (9) begin
			ticks(1);
			k += int'(sample_tick === 1'b1);
		end
		`CHK(k, 3)
		// Soft reset also undoes the power code left at held reset above.
		host_inst.wr(`ACRB_OFS_PORT_CFG, 8'h24);
		ticks(3);
		`CHK({dcs_enable, chop_enable, clock_divide, chip_run}, 6'b00_0001)
		rchk(`ACRB_OFS_PORT_CFG, `ACRB_RST_PORT_CFG);
		foreach (codes[i]) begin
			tst({4'h0, codes[i]});
			`CHK(lane_a, words[i])
		end
		foreach (alts[i]) begin
			tst({4'h0, alts[i]});
			prev = lane_a;
			ticks(1);
			`CHK(prev ^ lane_a, 12'hfff)
			`CHK(prev == his[i] || lane_a == his[i], 1'b1)
		end
		tst(8'h25);
		`CHK(lane_a, 12'hfff)
		tst(8'h05);
		k = 0;
		repeat (16) begin
			prev = lane_a;
			ticks(1);
			k += int'(prev !== lane_a);
		end
		`CHK(k > 0, 1'b1)
		tst(8'h48);
		prev = lane_a;
		ticks(1);
		`CHK(prev ^ lane_a, 12'h5a1 ^ 12'h0c3)
		tst(8'h00);
		tst(8'h88);
		ticks(3);
		`CHK(lane_a, 12'h000)
		tst(8'h01);
		host_inst.wr(`ACRB_OFS_CHAN_SEL, 8'h02);
		tst(8'h02);
		`CHK({lane_a, lane_b}, {`ACRB_W_MID, `ACRB_W_POS_FS})
		rchk(`ACRB_OFS_TEST, 8'h02);
		host_inst.wr(`ACRB_OFS_CHAN_SEL, 8'h33);
		rchk(`ACRB_OFS_TEST, 8'h01);
		host_inst.wr(`ACRB_OFS_COMMIT, 8'h01);
		k = 0;
		repeat (5) begin
			ticks(1);
			k += int'(override_commit === 1'b1);
		end
		`CHK(k, 1)
		rchk(`ACRB_OFS_COMMIT, 8'h00);
		tally_and_finish();
	end
endmodule
